// File: uxi_pkg.sv
// Shared constants and carrier types for the transfer interrupt block.
`default_nettype none
package uxi_pkg;
  // Status vector bit positions.
  localparam int ST_CMPL = 0;
  localparam int ST_ERR = 1;
  localparam int ST_HSE = 2;
  localparam int ST_HALT = 3;
  localparam int ST_W = 4;
  // Threshold field reset value, in micro-frames.
  localparam logic [7:0] THR_RST = 8'h08;
  // Enable and status reset values.
  localparam logic [ST_W-1:0] EN_RST = 4'h0;
  localparam logic [ST_W-1:0] ST_RST = 4'h8;
  // Status bits whose interrupt waits for a threshold boundary.
  localparam logic [ST_W-1:0] THR_MASK = 4'h3;
  // Descriptor error counter value that halts a queue head.
  localparam logic [1:0] CERR_LAST = 2'h1;

  // One finished bus transaction as reported by the protocol engine.
  typedef struct packed {
    logic crc;
    logic tmo;
    logic bad_pid;
    logic nak;
    logic nyet;
    logic setup;
    logic hs;
    logic csplit;
    logic qh;
    logic iso;
    logic is_in;
    logic buf_err;
    logic pid_mis;
    logic interrupt_on_completion_flag;
    logic done;
    logic short_pkt;
    logic [1:0] cerr;
    logic [10:0] rx_bytes;
    logic [10:0] total_bytes;
    logic [10:0] mps;
  } uxi_xact_t;

  // Descriptor side effects to be written back.
  typedef struct packed {
    logic xact_err;
    logic babble;
    logic buf_err;
    logic halt;
    logic [1:0] cerr;
  } uxi_desc_t;
endpackage
`default_nettype wire

// File: uxi_thresh.sv
// Micro-frame counter that marks each interrupt threshold boundary.
`timescale 1ns/1ps
`default_nettype none
module uxi_thresh #(
  parameter int CNT_W = 8
) (
  input wire logic core_clk, // Controller clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic uframe_tick, // One pulse per micro-frame.
  input wire logic [CNT_W-1:0] thr, // Threshold length in micro-frames.
  output logic boundary // Pulse on the last micro-frame of an interval.
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic bnd_ff;
  logic nxt_bnd;

  // Refuse counter widths too narrow for the default threshold.
  if (CNT_W < 4)
  begin : g_cnt_w_chk
    $error("uxi_thresh: CNT_W too small");
  end

  // Count micro-frames; a zero threshold behaves as one.
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_bnd = 1'b0;
    if (uframe_tick)
    begin
      if (cnt_ff + 1'b1 >= thr)
      begin
        nxt_cnt = '0;
        nxt_bnd = 1'b1;
      end
      else
      begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  // Register the counter and boundary pulse.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= '0;
      bnd_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      bnd_ff <= nxt_bnd;
    end
  end

  // The boundary pulse comes straight from its flop.
  assign boundary = bnd_ff;
endmodule // uxi_thresh
`default_nettype wire

// File: uxi_err_eval.sv
// Classifies one transaction result into descriptor and status effects.
`timescale 1ns/1ps
`default_nettype none
module uxi_err_eval (
  input wire logic core_clk, // Controller clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic xact_vld, // Pulse: xact holds a finished transaction.
  input wire uxi_pkg::uxi_xact_t xact, // Transaction result.
  output uxi_pkg::uxi_desc_t desc, // Descriptor write-back values.
  output logic res_vld, // Pulse: desc and flags are valid.
  output logic set_cmpl, // Pulse: raise completion flag.
  output logic set_err, // Pulse: raise error flag.
  output logic no_hshk, // Pulse: withhold the IN handshake.
  output logic crc_inv // Pulse: send OUT CRC inverted.
);
  uxi_pkg::uxi_desc_t desc_ff, nxt_desc;
  logic [4:0] ev_ff, nxt_ev;
  logic [10:0] lim;
  logic terr;
  logic babble;
  logic last;

  // Decide counter, halt and flag effects for this transaction.
  always_comb
  begin
    lim = (xact.total_bytes < xact.mps) ? xact.total_bytes : xact.mps;
    if (xact.pid_mis) lim = xact.mps;
    babble = xact.is_in && (xact.rx_bytes > lim);
    terr = xact.crc | xact.tmo | xact.bad_pid;
    if (xact.setup && ((xact.hs && (xact.nak | xact.nyet)) ||
        (!xact.hs && xact.csplit && xact.nak))) terr = 1'b1;
    last = xact.cerr == uxi_pkg::CERR_LAST;
    nxt_desc = '0;
    nxt_desc.cerr = xact.cerr;
    nxt_ev = '0;
    if (xact_vld)
    begin
      if (terr && !babble)
      begin
        nxt_desc.xact_err = 1'b1;
        if (xact.cerr != 2'h0) nxt_desc.cerr = xact.cerr - 2'h1;
        nxt_ev[1] = !xact.qh || last;
        nxt_desc.halt = xact.qh && last;
      end
      if (babble)
      begin
        nxt_desc.babble = 1'b1;
        nxt_desc.halt = xact.qh;
        nxt_ev[1] = 1'b1;
      end
      if (xact.buf_err)
      begin
        nxt_desc.buf_err = 1'b1;
        nxt_ev[2] = xact.is_in && !xact.iso;
        nxt_ev[3] = !xact.is_in;
      end
      nxt_ev[0] = (xact.done && xact.interrupt_on_completion_flag) ||
                  (xact.short_pkt && xact.qh && xact.is_in);
      if (xact.done && xact.interrupt_on_completion_flag && (terr || babble)) nxt_ev[1] = 1'b1;
      nxt_ev[4] = 1'b1;
    end
  end

  // Register results as one-cycle pulses.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      desc_ff <= '0;
      ev_ff <= '0;
    end
    else
    begin
      desc_ff <= nxt_desc;
      ev_ff <= nxt_ev;
    end
  end

  // Present the registered results as separate pulses.
  assign desc = desc_ff;
  assign set_cmpl = ev_ff[0];
  assign set_err = ev_ff[1];
  assign no_hshk = ev_ff[2];
  assign crc_inv = ev_ff[3];
  assign res_vld = ev_ff[4];
endmodule // uxi_err_eval
`default_nettype wire

// File: uxi_top.sv
// Transfer interrupt, threshold and transaction error control.
`timescale 1ns/1ps
`default_nettype none
module uxi_top #(
  parameter int THR_W = 8
) (
  input wire logic core_clk, // Controller clock, 10 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic uframe_tick, // Pulse at each micro-frame start.
  input wire logic cmd_wr, // Pulse: load command fields.
  input wire logic cmd_run, // Run value for command write.
  input wire logic [THR_W-1:0] cmd_thr, // Threshold value for command write.
  input wire logic en_wr, // Pulse: load interrupt enables.
  input wire logic [3:0] en_wdata, // Interrupt enable value.
  input wire logic sts_wr, // Pulse: write-one-to-clear status.
  input wire logic [3:0] sts_wdata, // Status bits to clear.
  input wire logic xact_vld, // Pulse: transaction finished.
  input wire uxi_pkg::uxi_xact_t xact, // Transaction result.
  input wire logic wb_done, // Pulse: status write-back completed.
  input wire logic host_err, // Pulse: host system error.
  input wire logic eof2_pt, // Pulse at the high-speed EOF2 point.
  input wire logic in_busy, // Level: IN transaction on the bus.
  input wire logic out_req, // Pulse: request to start an OUT.
  input wire logic [15:0] out_need, // Bit times the OUT needs.
  input wire logic [15:0] uf_left, // Bit times left to micro-frame end.
  output logic [3:0] status, // Status flags.
  output logic [3:0] int_en, // Interrupt enables.
  output logic run, // Run bit.
  output logic [THR_W-1:0] thr, // Threshold field.
  output uxi_pkg::uxi_desc_t desc, // Descriptor write-back values.
  output logic desc_vld, // Pulse: desc is valid.
  output logic no_hshk, // Pulse: withhold IN handshake.
  output logic crc_inv, // Pulse: invert OUT CRC bytes.
  output logic frame_babble, // Pulse: record frame babble.
  output logic port_dis, // Level: port disabled by frame babble.
  output logic out_go, // Pulse: OUT start granted.
  output logic out_deny, // Pulse: OUT start refused.
  output logic irq // Interrupt, active high.
);
  ////////////////////////////////////////////////////////////////////
  // Declarations and submodules.
  logic [3:0] sts_ff, nxt_sts, en_ff, nxt_en, set_v, clr_v;
  logic run_ff, nxt_run;
  logic [THR_W-1:0] thr_ff, nxt_thr;
  logic [1:0] lat_ff, nxt_lat;
  logic wb_busy_ff, nxt_wb_busy;
  logic irq_ff, nxt_irq;
  logic fb_ff, nxt_fb, pd_ff, nxt_pd;
  logic go_ff, nxt_go, deny_ff, nxt_deny;
  logic bnd, res_vld, set_cmpl, set_err;
  uxi_pkg::uxi_desc_t ev_desc;
  logic ev_nohs, ev_crc;

  // Refuse threshold widths that the counter and command port cannot serve.
  if (THR_W < 4 || THR_W > 16)
  begin : g_thr_w_chk
    $error("uxi_top: THR_W out of range");
  end

  uxi_thresh #(.CNT_W(THR_W)) u_thr (
    .core_clk(core_clk),
    .rst(rst),
    .uframe_tick(uframe_tick),
    .thr(thr_ff),
    .boundary(bnd)
  );

  uxi_err_eval u_eval (
    .core_clk(core_clk),
    .rst(rst),
    .xact_vld(xact_vld),
    .xact(xact),
    .desc(ev_desc),
    .res_vld(res_vld),
    .set_cmpl(set_cmpl),
    .set_err(set_err),
    .no_hshk(ev_nohs),
    .crc_inv(ev_crc)
  );

  ////////////////////////////////////////////////////////////////////
  // Command, enable and status registers.
  always_comb
  begin
    set_v = '0;
    set_v[uxi_pkg::ST_CMPL] = set_cmpl;
    set_v[uxi_pkg::ST_ERR] = set_err | (eof2_pt & in_busy);
    set_v[uxi_pkg::ST_HSE] = host_err;
    clr_v = sts_wr ? sts_wdata : 4'h0;
    clr_v[uxi_pkg::ST_HALT] = 1'b0;
    nxt_sts = (sts_ff & ~clr_v) | set_v;
    nxt_run = run_ff;
    nxt_thr = thr_ff;
    if (cmd_wr)
    begin
      nxt_run = cmd_run;
      nxt_thr = cmd_thr;
    end
    if (host_err) nxt_run = 1'b0;
    nxt_sts[uxi_pkg::ST_HALT] = !nxt_run;
    nxt_en = en_wr ? en_wdata : en_ff;
  end

  // Register command, enable and status state.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sts_ff <= uxi_pkg::ST_RST;
      en_ff <= uxi_pkg::EN_RST;
      run_ff <= 1'b0;
      thr_ff <= THR_W'(uxi_pkg::THR_RST);
    end
    else
    begin
      sts_ff <= nxt_sts;
      en_ff <= nxt_en;
      run_ff <= nxt_run;
      thr_ff <= nxt_thr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Threshold latch and interrupt output.
  always_comb
  begin
    nxt_wb_busy = wb_busy_ff;
    if (res_vld) nxt_wb_busy = 1'b1;
    else if (wb_done) nxt_wb_busy = 1'b0;
    nxt_lat = lat_ff & sts_ff[1:0];
    if (bnd && !wb_busy_ff)
      nxt_lat = nxt_lat | (sts_ff[1:0] & en_ff[1:0] & uxi_pkg::THR_MASK[1:0]);
    nxt_irq = (|nxt_lat) |
              (nxt_sts[uxi_pkg::ST_HSE] & en_ff[uxi_pkg::ST_HSE]);
  end

  // Register threshold latch, write-back tracking and interrupt.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      lat_ff <= 2'h0;
      wb_busy_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      lat_ff <= nxt_lat;
      wb_busy_ff <= nxt_wb_busy;
      irq_ff <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frame babble, port disable and OUT start guard.
  always_comb
  begin
    nxt_fb = eof2_pt & in_busy;
    nxt_pd = pd_ff | nxt_fb;
    if (cmd_wr && cmd_run && !run_ff) nxt_pd = nxt_fb;
    nxt_go = out_req & run_ff & (out_need <= uf_left);
    nxt_deny = out_req & !nxt_go;
  end

  // Register link-side pulses and the port disable level.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fb_ff <= 1'b0;
      pd_ff <= 1'b0;
      go_ff <= 1'b0;
      deny_ff <= 1'b0;
    end
    else
    begin
      fb_ff <= nxt_fb;
      pd_ff <= nxt_pd;
      go_ff <= nxt_go;
      deny_ff <= nxt_deny;
    end
  end

  // Every output is taken straight from a register.
  assign status = sts_ff;
  assign int_en = en_ff;
  assign run = run_ff;
  assign thr = thr_ff;
  assign desc = ev_desc;
  assign desc_vld = res_vld;
  assign no_hshk = ev_nohs;
  assign crc_inv = ev_crc;
  assign frame_babble = fb_ff;
  assign port_dis = pd_ff;
  assign out_go = go_ff;
  assign out_deny = deny_ff;
  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  w1c_clear_a: assert property (
    sts_wr && sts_wdata[0] && !set_cmpl |=> !status[0])
    else $error("completion flag not cleared by write of one");
  set_wins_a: assert property (
    set_err |=> status[1])
    else $error("error flag lost on set");
  hse_halt_a: assert property (
    host_err |=> !run && status[3] && status[2])
    else $error("host error did not halt");
  hse_irq_a: assert property (
    host_err && int_en[2] && !en_wr |=> irq)
    else $error("host error interrupt late");
  no_early_a: assert property (
    $rose(irq) && !status[2] |-> $past(bnd))
    else $error("threshold interrupt off boundary");
  wb_hold_a: assert property (
    bnd && wb_busy_ff && lat_ff == 2'h0 |=> lat_ff == 2'h0)
    else $error("interrupt raised before write-back");
  en_mask_a: assert property (
    bnd && !wb_busy_ff && (status[1:0] & en_ff[1:0]) == 2'h0 && lat_ff == 2'h0
    |=> lat_ff == 2'h0)
    else $error("masked source latched");
  out_guard_a: assert property (
    out_go |-> $past(out_need) <= $past(uf_left))
    else $error("OUT started across micro-frame end");
  fbab_port_a: assert property (
    eof2_pt && in_busy |=> frame_babble && port_dis && status[1])
    else $error("frame babble not handled");
  irq_hold_a: assert property (
    irq && !sts_wr && !$past(sts_wr) && !host_err && !cmd_wr |=> irq || status[2])
    else $error("interrupt dropped without status clear");

  // Transaction results as they reach the descriptor and the status flags.
  terr_dec_a: assert property (
    xact_vld && (xact.crc || xact.tmo || xact.bad_pid) && !xact.is_in && xact.cerr != 2'h0
    |=> desc.xact_err && desc.cerr == $past(xact.cerr) - 2'h1)
    else $error("transaction error did not decrement counter");
  qh_last_a: assert property (
    xact_vld && xact.qh && xact.crc && !xact.is_in && xact.cerr == 2'h1
    |=> set_err && desc.halt)
    else $error("queue head not halted on last error");
  qh_early_a: assert property (
    xact_vld && xact.qh && !xact.done && !xact.is_in && xact.cerr == 2'h2
    |=> !set_err && !desc.halt)
    else $error("queue head error flagged before counter end");
  setup_err_a: assert property (
    xact_vld && xact.setup && !xact.is_in && xact.hs && (xact.nak || xact.nyet) |=> desc.xact_err)
    else $error("setup handshake not counted as error");
  babble_halt_a: assert property (
    xact_vld && xact.is_in && xact.qh && xact.rx_bytes > xact.mps
    |=> desc.babble && desc.halt && desc.cerr == $past(xact.cerr))
    else $error("babble not flagged or counter touched");
  babble_err_a: assert property (
    xact_vld && xact.is_in && xact.rx_bytes > xact.mps |=> ##1 status[1])
    else $error("babble did not raise error flag");
  pid_mis_a: assert property (
    xact_vld && xact.is_in && xact.pid_mis && xact.rx_bytes <= xact.mps |=> !desc.babble)
    else $error("babble flagged within packet size on mismatch");
  buf_keep_a: assert property (
    xact_vld && xact.buf_err && !xact.crc && !xact.tmo && !xact.bad_pid && !xact.setup
    |=> desc.buf_err && !desc.xact_err && desc.cerr == $past(xact.cerr))
    else $error("buffer error counted as transaction error");
  in_nohs_a: assert property (
    xact_vld && xact.buf_err && xact.is_in && !xact.iso |=> no_hshk && !crc_inv)
    else $error("handshake not withheld on IN buffer error");
  out_crc_a: assert property (
    xact_vld && xact.buf_err && !xact.is_in |=> crc_inv && !no_hshk)
    else $error("OUT buffer error did not corrupt CRC");
  ioc_cmpl_a: assert property (
    xact_vld && xact.done && xact.interrupt_on_completion_flag |=> ##1 status[0])
    else $error("marked completion did not raise flag");
  ioc_err_a: assert property (
    xact_vld && xact.done && xact.interrupt_on_completion_flag && xact.crc |=> ##1 status[1:0] == 2'h3)
    else $error("erroneous completion missing a flag");
  short_cmpl_a: assert property (
    xact_vld && xact.short_pkt && xact.qh && xact.is_in |=> ##1 status[0])
    else $error("short packet did not raise completion flag");
  thr_load_a: assert property (
    cmd_wr |=> thr == $past(cmd_thr))
    else $error("threshold field not loaded");
  irq_src_a: assert property (
    irq && !status[2] |-> lat_ff != 2'h0)
    else $error("interrupt without a latched source");
endmodule // uxi_top
`default_nettype wire

// File: uxi_usb_dev.sv
// Behavioural model of a USB endpoint answering the host's transactions.
`timescale 1ns/1ps
`default_nettype none
module uxi_usb_dev (
  input wire logic core_clk, // Controller clock.
  input wire logic rst, // Reset, active high.
  input wire logic go, // Pulse: host issues a token.
  input wire uxi_pkg::uxi_xact_t host, // Host side fields.
  input wire logic [2:0] rsp, // 1 crc, 2 timeout, 3 bad pid, 4 nak, 5 nyet.
  input wire logic [10:0] rx_len, // Bytes the endpoint sends.
  input wire logic pid_mis, // Endpoint repeats an old data PID.
  input wire logic [3:0] wait_cyc, // Answer delay in cycles.
  output logic xact_vld, // Pulse: answer complete.
  output uxi_pkg::uxi_xact_t xact // Merged transaction result.
);
  uxi_pkg::uxi_xact_t req_ff;
  logic busy_ff;
  logic [3:0] cnt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Holds an answer for the delay, shows it for one cycle, and toggles the
  // result lines between answers so that a stale value is never trusted.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      req_ff <= '0;
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      xact_vld <= 1'b0;
      xact <= '0;
    end
    else
    begin
      xact_vld <= 1'b0;
      xact <= ~xact;
      if (go)
      begin
        busy_ff <= 1'b1;
        cnt_ff <= wait_cyc;
        req_ff <= host;
        req_ff.crc <= rsp == 3'h1;
        req_ff.tmo <= rsp == 3'h2;
        req_ff.bad_pid <= rsp == 3'h3;
        req_ff.nak <= rsp == 3'h4;
        req_ff.nyet <= rsp == 3'h5;
        req_ff.rx_bytes <= rx_len;
        req_ff.pid_mis <= pid_mis;
        req_ff.short_pkt <= host.is_in && rx_len < host.mps;
      end
      else if (busy_ff && cnt_ff == 4'h0)
      begin
        xact_vld <= 1'b1;
        xact <= req_ff;
        busy_ff <= 1'b0;
      end
      else if (busy_ff)
        cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule // uxi_usb_dev
`default_nettype wire

// File: tb_usb_host_xfer_interrupts.sv
// Self-checking bench for the transfer interrupt block.
`timescale 1ns/1ps
`default_nettype none
module tb_usb_host_xfer_interrupts;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic uframe_tick = 1'b0;
  logic cmd_wr = 1'b0;
  logic cmd_run = 1'b0;
  logic [7:0] cmd_thr = 8'h00;
  logic en_wr = 1'b0;
  logic [3:0] en_wdata = 4'h0;
  logic sts_wr = 1'b0;
  logic [3:0] sts_wdata = 4'h0;
  logic wb_done = 1'b0;
  logic host_err = 1'b0;
  logic eof2_pt = 1'b0;
  logic in_busy = 1'b0;
  logic out_req = 1'b0;
  logic [15:0] out_need = 16'h0000;
  logic [15:0] uf_left = 16'h0000;
  logic go = 1'b0;
  logic [2:0] rsp = 3'h0;
  logic [10:0] rx_len = 11'h000;
  logic pid_mis = 1'b0;
  logic [3:0] wait_cyc = 4'h0;
  uxi_pkg::uxi_xact_t h = '0;
  uxi_pkg::uxi_xact_t xact;
  uxi_pkg::uxi_desc_t desc;
  logic xact_vld, desc_vld, no_hshk, crc_inv, frame_babble, port_dis;
  logic out_go, out_deny, irq, run;
  logic [3:0] status, int_en;
  logic [7:0] thr;
  int bad_count = 0;
  int tests_run = 0;

  uxi_usb_dev i_uxi_usb_dev (.core_clk(core_clk), .rst(rst), .go(go), .host(h),
    .rsp(rsp), .rx_len(rx_len), .pid_mis(pid_mis), .wait_cyc(wait_cyc),
    .xact_vld(xact_vld), .xact(xact));

  uxi_top #(.THR_W(8)) i_uxi_top (.core_clk(core_clk), .rst(rst),
    .uframe_tick(uframe_tick), .cmd_wr(cmd_wr), .cmd_run(cmd_run), .cmd_thr(cmd_thr),
    .en_wr(en_wr), .en_wdata(en_wdata), .sts_wr(sts_wr), .sts_wdata(sts_wdata),
    .xact_vld(xact_vld), .xact(xact), .wb_done(wb_done), .host_err(host_err),
    .eof2_pt(eof2_pt), .in_busy(in_busy), .out_req(out_req), .out_need(out_need),
    .uf_left(uf_left), .status(status), .int_en(int_en), .run(run), .thr(thr),
    .desc(desc), .desc_vld(desc_vld), .no_hshk(no_hshk), .crc_inv(crc_inv),
    .frame_babble(frame_babble), .port_dis(port_dis), .out_go(out_go),
    .out_deny(out_deny), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic results;
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Pulses the command and enable loads, then lets the outputs settle.
  task automatic cfg(input logic c, input logic r, input logic [7:0] t, input logic e,
    input logic [3:0] ev);
    @(posedge core_clk);
    cmd_wr <= c;
    cmd_run <= r;
    cmd_thr <= t;
    en_wr <= e;
    en_wdata <= ev;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
    en_wr <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  // Clears status bits and reports the descriptor write-back as finished.
  task automatic sw(input logic [3:0] v);
    @(posedge core_clk);
    sts_wr <= 1'b1;
    sts_wdata <= v;
    wb_done <= 1'b1;
    @(posedge core_clk);
    sts_wr <= 1'b0;
    wb_done <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(8'(status & v & 4'h7), 8'h00);
  endtask

  // One micro-frame start; with a threshold of one it closes an interval.
  task automatic tk;
    @(posedge core_clk);
    uframe_tick <= 1'b1;
    @(posedge core_clk);
    uframe_tick <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // Plain full-length transfer with a fresh error counter and a prompt answer.
  task automatic base;
    h = '0;
    h.mps = 11'h040;
    h.total_bytes = 11'h040;
    h.cerr = 2'h3;
    pid_mis = 1'b0;
    wait_cyc = 4'h0;
  endtask

  // Runs one transaction; es holds no-handshake, inverted CRC, then status.
  task automatic xf(input logic [2:0] r, input logic [10:0] n, input logic [5:0] ed,
    input logic [3:0] es, input logic keep);
    int w;
    rsp = r;
    rx_len = n;
    @(posedge core_clk);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    w = 0;
    while (xact_vld !== 1'b1 && w < 20)
    begin
      @(posedge core_clk);
      #1;
      w++;
    end
    @(posedge core_clk);
    #1;
    chk(8'({desc_vld, desc}), {2'h1, ed});
    chk(8'({no_hshk, crc_inv}), 8'(es[3:2]));
    @(posedge core_clk);
    #1;
    chk(8'(status[1:0]), 8'(es[1:0]));
    if (!keep)
      sw(4'h7);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 100 ns.
  initial
    forever #50 core_clk = ~core_clk;

  // Cuts a hung run short.
  initial
  begin
    #(3000 * 100);
    bad_count++;
    results();
  end

  // Main sequence.
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({status, int_en}, 8'h80);
    chk(8'({run, irq, port_dis}), 8'h00);
    chk(thr, 8'h08);
    cfg(1'b1, 1'b1, 8'h01, 1'b1, 4'h0);
    chk(8'({run, int_en}), 8'h10);
    chk(thr, 8'h01);
    base();
    for (int k = 1; k < 4; k++)
      xf(3'(k), 11'h040, 6'h22, 4'h2, 1'b0);
    h.qh = 1'b1;
    h.cerr = 2'h2;
    xf(3'h1, 11'h040, 6'h21, 4'h0, 1'b0);
    h.cerr = 2'h1;
    xf(3'h2, 11'h040, 6'h24, 4'h2, 1'b0);
    base();
    h.qh = 1'b1;
    h.setup = 1'b1;
    h.hs = 1'b1;
    xf(3'h4, 11'h040, 6'h22, 4'h0, 1'b0);
    xf(3'h5, 11'h040, 6'h22, 4'h0, 1'b0);
    h.hs = 1'b0;
    h.csplit = 1'b1;
    xf(3'h4, 11'h040, 6'h22, 4'h0, 1'b0);
    base();
    h.qh = 1'b1;
    h.is_in = 1'b1;
    wait_cyc = 4'h3;
    xf(3'h0, 11'h041, 6'h17, 4'h2, 1'b0);
    h.total_bytes = 11'h020;
    pid_mis = 1'b1;
    xf(3'h0, 11'h028, 6'h03, 4'h1, 1'b0);
    base();
    h.qh = 1'b1;
    h.is_in = 1'b1;
    h.buf_err = 1'b1;
    xf(3'h0, 11'h040, 6'h0B, 4'h8, 1'b0);
    h.is_in = 1'b0;
    xf(3'h0, 11'h040, 6'h0B, 4'h4, 1'b0);
    base();
    h.done = 1'b1;
    h.interrupt_on_completion_flag = 1'b1;
    xf(3'h1, 11'h040, 6'h22, 4'h3, 1'b0);
    cfg(1'b0, 1'b1, 8'h01, 1'b1, 4'h3);
    xf(3'h0, 11'h040, 6'h03, 4'h1, 1'b1);
    repeat (6) @(posedge core_clk);
    #1;
    chk(8'(irq), 8'h00);
    tk();
    chk(8'(irq), 8'h00);
    sw(4'h0);
    tk();
    chk(8'(irq), 8'h01);
    cfg(1'b0, 1'b1, 8'h01, 1'b1, 4'h0);
    chk(8'(irq), 8'h01);
    sw(4'h1);
    chk(8'(irq), 8'h00);
    cfg(1'b0, 1'b1, 8'h01, 1'b1, 4'h2);
    xf(3'h0, 11'h040, 6'h03, 4'h1, 1'b1);
    sw(4'h0);
    tk();
    chk(8'(irq), 8'h00);
    sw(4'h7);
    @(posedge core_clk);
    in_busy <= 1'b1;
    eof2_pt <= 1'b1;
    @(posedge core_clk);
    eof2_pt <= 1'b0;
    in_busy <= 1'b0;
    #1;
    chk(8'({frame_babble, port_dis, status[1]}), 8'h07);
    sw(4'h7);
    cfg(1'b1, 1'b0, 8'h01, 1'b0, 4'h0);
    cfg(1'b1, 1'b1, 8'h01, 1'b0, 4'h0);
    chk(8'(port_dis), 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk);
      out_req <= 1'b1;
      out_need <= 16'h0064;
      uf_left <= 16'h0063 + 16'(k);
      @(posedge core_clk);
      out_req <= 1'b0;
      #1;
      chk(8'({out_go, out_deny}), k ? 8'h02 : 8'h01);
    end
    cfg(1'b0, 1'b1, 8'h01, 1'b1, 4'h4);
    @(posedge core_clk);
    host_err <= 1'b1;
    @(posedge core_clk);
    host_err <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(8'({irq, run, status[3:2]}), 8'h0B);
    results();
  end
endmodule // tb_usb_host_xfer_interrupts
`default_nettype wire
